/* File: rtl/rre_exec.sv */
// execution of return and rotate-left instructions inside the core
// Function
// - a subroutine exit reloads the pc from the return stack top and touches no flag.
// - a subroutine exit with literal reloads the pc and writes the immediate into the accumulator.
// - an interrupt exit reloads the pc and sets the global interrupt enable to 1, no flags.
// - an interrupt exit with an interrupt pending services that interrupt before resuming.
// - rotate left in place rotates the data byte left by one, bit 7 into bit 0, and writes it back.
// - rotate left to accumulator writes the same rotation only to the accumulator, memory kept.
`timescale 1ns/100ps
module rre_exec
   import rre_pkg::*;
#(
   parameter int PC_W = rre_pkg::RRE_PC_W_DEF,
   parameter int ADDR_W = rre_pkg::RRE_ADDR_W_DEF
) (
   // clock, reset, enable
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic ce_in,
   // decoded instruction issue
   input wire logic op_valid_in,
   input wire rre_pkg::rre_op_e op_code_in,
   input wire logic [rre_pkg::RRE_DATA_W-1:0] op_imm_in,
   input wire logic [ADDR_W-1:0] op_addr_in,
   output logic op_ready_out,
   // return stack
   input wire logic [PC_W-1:0] stack_top_in,
   output logic stack_pop_out,
   // program counter
   output logic pc_load_out,
   output logic [PC_W-1:0] pc_value_out,
   // accumulator
   output logic acc_we_out,
   output logic [rre_pkg::RRE_DATA_W-1:0] acc_data_out,
   // data memory, read data one cycle after the read strobe
   output logic mem_rd_out,
   output logic mem_we_out,
   output logic [ADDR_W-1:0] mem_addr_out,
   output logic [rre_pkg::RRE_DATA_W-1:0] mem_wdata_out,
   input wire logic [rre_pkg::RRE_DATA_W-1:0] mem_rdata_in,
   // interrupt controller
   input wire logic irq_pending_in,
   output logic global_interrupt_enable_set_out,
   output logic irq_service_out
);
   import rre_pkg::*;

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   typedef struct packed {
      rre_state_e state;
      logic to_acc;
      logic pc_load;
      logic [PC_W-1:0] pc_value;
      logic stack_pop;
      logic acc_we;
      logic [RRE_DATA_W-1:0] acc_data;
      logic mem_rd;
      logic mem_we;
      logic [ADDR_W-1:0] mem_addr;
      logic [RRE_DATA_W-1:0] mem_wdata;
      logic gie_set;
      logic irq_service;
   } rre_exec_s;

   rre_exec_s cur;
   rre_exec_s next_cur;
   logic [RRE_DATA_W-1:0] rot_result;
   logic take;

   // ------------------------------------------------------------------
   // rotator
   // ------------------------------------------------------------------
   rre_rotl #(
      .W(RRE_DATA_W)
   ) u_rotl (
      .data_in(mem_rdata_in),
      .data_out(rot_result)
   );

   // new instruction only accepted while idle, so rotates stall the issue path
   assign op_ready_out = (cur.state == ST_IDLE);
   assign take = op_valid_in && op_ready_out;

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   // strobes are one-cycle pulses; no flag write path exists here at all
   always_comb
   begin
      next_cur = cur;
      next_cur.pc_load = 1'b0;
      next_cur.stack_pop = 1'b0;
      next_cur.acc_we = 1'b0;
      next_cur.mem_rd = 1'b0;
      next_cur.mem_we = 1'b0;
      next_cur.gie_set = 1'b0;
      next_cur.irq_service = 1'b0;
      case (cur.state)
         ST_IDLE:
         begin
            if (take)
            begin
               case (op_code_in)
                  OP_SUBROUTINE_EXIT,
                  OP_SUBROUTINE_EXIT_WITH_LITERAL,
                  OP_INTERRUPT_EXIT:
                  begin
                     next_cur.pc_load = 1'b1;
                     next_cur.pc_value = stack_top_in;
                     next_cur.stack_pop = 1'b1;
                     if (op_code_in == OP_SUBROUTINE_EXIT_WITH_LITERAL)
                     begin
                        next_cur.acc_we = 1'b1;
                        next_cur.acc_data = op_imm_in;
                     end
                     if (op_code_in == OP_INTERRUPT_EXIT)
                     begin
                        next_cur.gie_set = RRE_BIT_SET[0];
                        // pending request is vectored first; the popped pc is
                        // what the controller pushes as its return address
                        next_cur.irq_service = irq_pending_in;
                     end
                  end
                  OP_ROTATE_LEFT_IN_PLACE,
                  OP_ROTATE_LEFT_TO_ACCUMULATOR:
                  begin
                     next_cur.state = ST_READ;
                     next_cur.mem_rd = 1'b1;
                     next_cur.mem_addr = op_addr_in;
                     next_cur.to_acc = (op_code_in == OP_ROTATE_LEFT_TO_ACCUMULATOR);
                  end
                  default:
                  begin
                     next_cur.state = ST_IDLE;
                  end
               endcase
            end
         end
         ST_READ:
         begin
            // memory answers in the cycle after the read strobe
            next_cur.state = ST_WRITE;
         end
         ST_WRITE:
         begin
            next_cur.state = ST_IDLE;
            if (cur.to_acc)
            begin
               next_cur.acc_we = 1'b1;
               next_cur.acc_data = rot_result;
            end
            else
            begin
               next_cur.mem_we = 1'b1;
               next_cur.mem_wdata = rot_result;
            end
         end
         default:
         begin
            next_cur.state = ST_IDLE;
         end
      endcase
   end

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   // clock enable low freezes everything, strobes included
   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         cur <= '0;
         cur.state <= ST_IDLE;
      end
      else if (ce_in)
      begin
         cur <= next_cur;
      end
   end

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   assign pc_load_out = cur.pc_load;
   assign pc_value_out = cur.pc_value;
   assign stack_pop_out = cur.stack_pop;
   assign acc_we_out = cur.acc_we;
   assign acc_data_out = cur.acc_data;
   assign mem_rd_out = cur.mem_rd;
   assign mem_we_out = cur.mem_we;
   assign mem_addr_out = cur.mem_addr;
   assign mem_wdata_out = cur.mem_wdata;
   assign global_interrupt_enable_set_out = cur.gie_set;
   assign irq_service_out = cur.irq_service;

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   property p_sub_exit;
      @(posedge clk_sys_in) disable iff (rst_in)
      (ce_in && take && op_code_in == OP_SUBROUTINE_EXIT) |=>
         pc_load_out && pc_value_out == $past(stack_top_in) && !acc_we_out
         && !global_interrupt_enable_set_out;
   endproperty
   a_sub_exit: assert property (p_sub_exit)
      else $error("subroutine exit did not reload pc cleanly");

   property p_lit_exit;
      @(posedge clk_sys_in) disable iff (rst_in)
      (ce_in && take && op_code_in == OP_SUBROUTINE_EXIT_WITH_LITERAL) |=>
         pc_load_out && acc_we_out && acc_data_out == $past(op_imm_in);
   endproperty
   a_lit_exit: assert property (p_lit_exit)
      else $error("literal exit lost pc reload or immediate");

   property p_int_exit;
      @(posedge clk_sys_in) disable iff (rst_in)
      (ce_in && take && op_code_in == OP_INTERRUPT_EXIT) |=>
         global_interrupt_enable_set_out && pc_load_out && !acc_we_out;
   endproperty
   a_int_exit: assert property (p_int_exit)
      else $error("interrupt exit did not set global enable");

   property p_int_pending;
      @(posedge clk_sys_in) disable iff (rst_in)
      (irq_service_out && $past(ce_in)) |-> global_interrupt_enable_set_out && pc_load_out
         && $past(irq_pending_in);
   endproperty
   a_int_pending: assert property (p_int_pending)
      else $error("interrupt service without pending interrupt exit");

   property p_rot_mem;
      @(posedge clk_sys_in) disable iff (rst_in)
      (mem_we_out && $past(ce_in)) |->
         mem_wdata_out == {$past(mem_rdata_in[6:0]), $past(mem_rdata_in[7])}
         && !acc_we_out && $past(cur.state == ST_WRITE, 1);
   endproperty
   a_rot_mem: assert property (p_rot_mem)
      else $error("in-place rotate result wrong");

   property p_rot_acc;
      @(posedge clk_sys_in) disable iff (rst_in)
      (acc_we_out && !pc_load_out && $past(ce_in)) |->
         acc_data_out == {$past(mem_rdata_in[6:0]), $past(mem_rdata_in[7])}
         && !mem_we_out;
   endproperty
   a_rot_acc: assert property (p_rot_acc)
      else $error("accumulator rotate result wrong or memory written");

   property p_one_pop;
      @(posedge clk_sys_in) disable iff (rst_in)
      (stack_pop_out == pc_load_out) and (ce_in && !take |=> !stack_pop_out);
   endproperty
   a_one_pop: assert property (p_one_pop)
      else $error("stack pop not paired one to one with pc reload");

   property p_rot_read;
      @(posedge clk_sys_in) disable iff (rst_in)
      (ce_in && take && (op_code_in == OP_ROTATE_LEFT_IN_PLACE
         || op_code_in == OP_ROTATE_LEFT_TO_ACCUMULATOR)) |=>
         mem_rd_out && mem_addr_out == $past(op_addr_in) && !op_ready_out;
   endproperty
   a_rot_read: assert property (p_rot_read)
      else $error("rotate did not read the addressed byte");

   c_int_pending: cover property (@(posedge clk_sys_in) disable iff (rst_in)
      irq_service_out);
   c_rot_mem: cover property (@(posedge clk_sys_in) disable iff (rst_in)
      mem_we_out);
   c_rot_acc: cover property (@(posedge clk_sys_in) disable iff (rst_in)
      acc_we_out && !pc_load_out);
   c_lit_exit: cover property (@(posedge clk_sys_in) disable iff (rst_in)
      acc_we_out && pc_load_out);

endmodule : rre_exec

/* File: rtl/rre_pkg.sv */
// shared types and constants for the return and rotate execution block
package rre_pkg;

   // ------------------------------------------------------------------
   // widths
   // ------------------------------------------------------------------
   localparam int RRE_DATA_W = 8;
   localparam int RRE_PC_W_DEF = 12;
   localparam int RRE_ADDR_W_DEF = 8;

   // ------------------------------------------------------------------
   // reset values and operations
   // ------------------------------------------------------------------
   localparam logic [RRE_DATA_W-1:0] RRE_DATA_RST = 8'h00;
   localparam logic [0:0] RRE_BIT_SET = 1'h1;

   typedef enum logic [2:0] {
      OP_SUBROUTINE_EXIT,
      OP_SUBROUTINE_EXIT_WITH_LITERAL,
      OP_INTERRUPT_EXIT,
      OP_ROTATE_LEFT_IN_PLACE,
      OP_ROTATE_LEFT_TO_ACCUMULATOR
   } rre_op_e;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_READ,
      ST_WRITE
   } rre_state_e;

endpackage : rre_pkg

/* File: rtl/rre_rotl.sv */
// one-position left rotation, msb wraps into lsb
`timescale 1ns/100ps
module rre_rotl #(
   parameter int W = 8
) (
   // operand and result
   input wire logic [W-1:0] data_in,
   output logic [W-1:0] data_out
);

   // ------------------------------------------------------------------
   // rotation
   // ------------------------------------------------------------------
   // old top bit lands in bit 0; no carry involved
   always_comb
   begin
      data_out = {data_in[W-2:0], data_in[W-1]};
   end

endmodule : rre_rotl

/* File: verif/rre_exec_tb.sv */
// self-checking testbench for the return and rotate execution block
`timescale 1ns/100ps
module testbench;
   import rre_pkg::*;

   // ------------------------------------------------------------------
   // stimulus and observed signals
   // ------------------------------------------------------------------
   logic clk_sys_in = 1'b0;
   logic rst_in = 1'b1;
   logic ce_in = 1'b1;
   logic op_valid_in = 1'b0;
   rre_op_e op_code_in = OP_SUBROUTINE_EXIT;
   logic [7:0] op_imm_in = 8'h00;
   logic [7:0] op_addr_in = 8'h00;
   logic [11:0] stack_top_in = 12'h000;
   logic [7:0] mem_rdata_in = 8'h00;
   logic irq_pending_in = 1'b0;
   logic op_ready_out, stack_pop_out, pc_load_out, acc_we_out, mem_rd_out, mem_we_out;
   logic gie_set, irq_service_out;
   logic [11:0] pc_value_out;
   logic [7:0] acc_data_out, mem_addr_out, mem_wdata_out;
   int errors = 0;
   int cmp_count = 0;
   int seed;
   int exp_pops = 0;
   int pops = 0;
   int loads = 0;

   rre_exec #(.PC_W(12), .ADDR_W(8)) DUT (
      .clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(ce_in),
      .op_valid_in(op_valid_in), .op_code_in(op_code_in), .op_imm_in(op_imm_in),
      .op_addr_in(op_addr_in), .op_ready_out(op_ready_out),
      .stack_top_in(stack_top_in), .stack_pop_out(stack_pop_out),
      .pc_load_out(pc_load_out), .pc_value_out(pc_value_out),
      .acc_we_out(acc_we_out), .acc_data_out(acc_data_out),
      .mem_rd_out(mem_rd_out), .mem_we_out(mem_we_out), .mem_addr_out(mem_addr_out),
      .mem_wdata_out(mem_wdata_out), .mem_rdata_in(mem_rdata_in),
      .irq_pending_in(irq_pending_in), .global_interrupt_enable_set_out(gie_set),
      .irq_service_out(irq_service_out)
   );

   // ------------------------------------------------------------------
   // clock, pulse counters and watchdog
   // ------------------------------------------------------------------
   always #12.5 clk_sys_in = ~clk_sys_in;

   // counting pulses on enabled edges catches a doubled pop or an op taken while refused
   always @(posedge clk_sys_in)
   begin
      if (ce_in && stack_pop_out === 1'b1) pops++;
      if (ce_in && pc_load_out === 1'b1) loads++;
   end

   // the whole sequence needs about 600 cycles, so 4000 means a hang
   initial
   begin
      #(25 * 4000);
      errors++;
      stop_test();
   end

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   task automatic stop_test();
      if (errors == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : stop_test

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // all strobes low and ready high, as after any reset
   task automatic chk_idle();
      chk("op_ready", 1, op_ready_out);
      chk("strobes", 0, {pc_load_out, stack_pop_out, acc_we_out, mem_rd_out, mem_we_out,
                         gie_set, irq_service_out});
   endtask : chk_idle

   function automatic logic [7:0] exp_rotl(input logic [7:0] d);
      return {d[6:0], d[7]};
   endfunction : exp_rotl

   // one instruction; returns leave valid high so the next one follows back to back
   task automatic do_op(input rre_op_e op, input logic [8:0] rdx, input bit poke);
      logic [7:0] imm;
      logic [7:0] addr;
      logic [7:0] rd;
      logic [11:0] top;
      logic pend;
      imm = 8'($random(seed));
      addr = 8'($random(seed));
      top = 12'($random(seed));
      pend = 1'($random(seed));
      rd = rdx[8] ? rdx[7:0] : 8'($random(seed));
      chk("op_ready", 1, op_ready_out);
      op_valid_in = 1'b1;
      op_code_in = op;
      op_imm_in = imm;
      op_addr_in = addr;
      stack_top_in = top;
      irq_pending_in = pend;
      @(posedge clk_sys_in);
      #2;
      if (op inside {OP_SUBROUTINE_EXIT, OP_SUBROUTINE_EXIT_WITH_LITERAL, OP_INTERRUPT_EXIT})
      begin
         exp_pops++;
         chk("pc_load", 1, pc_load_out);
         chk("pc_value", top, pc_value_out);
         chk("stack_pop", 1, stack_pop_out);
         chk("acc_we", op == OP_SUBROUTINE_EXIT_WITH_LITERAL, acc_we_out);
         if (op == OP_SUBROUTINE_EXIT_WITH_LITERAL)
            chk("acc_data", imm, acc_data_out);
         chk("gie_set", op == OP_INTERRUPT_EXIT, gie_set);
         chk("irq_service", op == OP_INTERRUPT_EXIT && pend, irq_service_out);
         chk("mem_access", 0, {mem_rd_out, mem_we_out});
      end
      else
      begin
         chk("mem_rd", 1, mem_rd_out);
         chk("mem_addr", addr, mem_addr_out);
         chk("op_ready", 0, op_ready_out);
         mem_rdata_in = rd;
         op_code_in = OP_SUBROUTINE_EXIT;
         op_valid_in = poke;
         @(posedge clk_sys_in);
         #2;
         op_valid_in = 1'b0;
         chk("mem_rd", 0, mem_rd_out);
         @(posedge clk_sys_in);
         #2;
         // read data no longer valid, so show something wrong on the bus
         mem_rdata_in = ~rd;
         chk("mem_we", op == OP_ROTATE_LEFT_IN_PLACE, mem_we_out);
         chk("acc_we", op == OP_ROTATE_LEFT_TO_ACCUMULATOR, acc_we_out);
         if (op == OP_ROTATE_LEFT_IN_PLACE)
            chk("mem_wdata", exp_rotl(rd), mem_wdata_out);
         else
            chk("acc_data", exp_rotl(rd), acc_data_out);
         chk("pc_load", 0, pc_load_out);
      end
   endtask : do_op

   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial
   begin
      seed = 91379;
      repeat (12) @(posedge clk_sys_in);
      #2;
      chk_idle();
      rst_in = 1'b0;
      for (int i = 0; i < 5; i++)
         do_op(rre_op_e'(i), 9'h000, 1'b0);
      // bit 7 must wrap, and a return offered while busy must be ignored
      do_op(OP_ROTATE_LEFT_IN_PLACE, 9'h180, 1'b1);
      do_op(OP_ROTATE_LEFT_TO_ACCUMULATOR, 9'h101, 1'b1);
      do_op(OP_ROTATE_LEFT_IN_PLACE, 9'h17F, 1'b0);
      // frozen enable: no take, and a pulse already out stays out
      ce_in = 1'b0;
      op_valid_in = 1'b1;
      op_code_in = OP_SUBROUTINE_EXIT;
      stack_top_in = 12'h5A3;
      @(posedge clk_sys_in);
      #2;
      chk("frozen_take", 0, {pc_load_out, stack_pop_out});
      ce_in = 1'b1;
      @(posedge clk_sys_in);
      #2;
      exp_pops++;
      ce_in = 1'b0;
      op_valid_in = 1'b0;
      chk("pc_value", 12'h5A3, pc_value_out);
      @(posedge clk_sys_in);
      #2;
      chk("frozen_pop", 2'h3, {pc_load_out, stack_pop_out});
      ce_in = 1'b1;
      // an unknown code is ignored and leaves every strobe low
      op_valid_in = 1'b1;
      op_code_in = rre_op_e'(3'h7);
      @(posedge clk_sys_in);
      #2;
      chk_idle();
      repeat (300)
         do_op(rre_op_e'(($random(seed) & 32'h7FFF) % 5), 9'h000, 1'($random(seed)));
      op_valid_in = 1'b0;
      // reset in the middle of a rotate
      @(posedge clk_sys_in);
      #2;
      op_valid_in = 1'b1;
      op_code_in = OP_ROTATE_LEFT_IN_PLACE;
      @(posedge clk_sys_in);
      #2;
      op_valid_in = 1'b0;
      rst_in = 1'b1;
      #1;
      chk_idle();
      repeat (2) @(posedge clk_sys_in);
      #2;
      rst_in = 1'b0;
      do_op(OP_SUBROUTINE_EXIT, 9'h000, 1'b0);
      op_valid_in = 1'b0;
      repeat (2) @(posedge clk_sys_in);
      #2;
      chk("pop_count", exp_pops, pops);
      chk("load_count", exp_pops, loads);
      stop_test();
   end
endmodule : testbench
